// *** rtl/hfp_pkg.sv ***
package hfp_pkg;
  localparam int DW     = 32;
  localparam int AW     = 8;
  localparam int FDEPTH = 16;
  localparam int FCW    = 5;
  localparam int FPW    = 4;
  localparam int NF     = 4;
  // fifo slots
  localparam int F_RXD  = 0;
  localparam int F_RXS  = 1;
  localparam int F_TXS  = 2;
  localparam int F_TXD  = 3;
  // host byte addresses
  localparam logic [AW-1:0] OFS_DATA_HI  = 8'h3C;
  localparam logic [AW-1:0] OFS_RXS_POP  = 8'h40;
  localparam logic [AW-1:0] OFS_RXS_PEEK = 8'h44;
  localparam logic [AW-1:0] OFS_TXS_POP  = 8'h48;
  localparam logic [AW-1:0] OFS_TXS_PEEK = 8'h4C;
  localparam logic [AW-1:0] OFS_LEVEL    = 8'h50;
  localparam logic [AW-1:0] OFS_EVENT    = 8'h54;
  localparam logic [AW-1:0] OFS_CFG      = 8'h58;
  localparam logic [AW-1:0] OFS_CTRL     = 8'h5C;
  // event register bits
  localparam int EV_W1C = 0;
  localparam int EV_RC  = 1;
  localparam int EV_LH  = 2;
  localparam int EV_LL  = 3;
  localparam logic [3:0] EV_RST = 4'h8;
  // level fields, one byte lane per fifo; config limits in lanes 0-2, retained field in lane 3
  localparam int LANE_W       = 8;
  localparam int CFG_KEEP_LSB = 24;
  localparam int CFG_KEEP_W   = 8;
  localparam logic [DW-1:0] CFG_RST = 32'h0010_1010;
  localparam logic [FCW-1:0] LIM_FIX = 5'h10;
  localparam int CTRL_SRST = 0;
  localparam logic [DW-1:0] ZERO_W = 32'h0000_0000;

  typedef struct packed {
    logic [NF-1:0][FDEPTH-1:0][DW-1:0] mem;
    logic [NF-1:0][FCW-1:0]            cnt;
    logic [NF-1:0][FPW-1:0]            rptr;
    logic [DW-1:0]                     cfg;
    logic [3:0]                        ev;
    logic                              srst_pend;
    logic [DW-1:0]                     rdata;
    logic                              rvalid;
    logic [DW-1:0]                     txd_out;
    logic                              txd_valid;
  } hfp_state_t;
endpackage

// *** rtl/hfp_top.sv ***
// Functional notes
// - writes to read-only fields change nothing
// - write-only register reads back as zero
// - writing one clears bit, zero keeps
// - read-to-clear bits drop when read
// - latched bits hold until register read
// - hardware reset restores register defaults; soft reset restores all but the retained field
// - retained field survives software reset
// - four fifos, three depth limits configurable
// - rx status pop returns and removes head
// - rx status peek returns head, keeps it
// - rx data pops at sixteen aliases
// - tx status pop returns and removes head
// - tx status peek returns head, keeps it
// - tx data push-only at sixteen aliases
// - host writes to rx ports ignored
`timescale 1ns/10ps
module hfp_top (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      host_rd,
  input  wire logic                      host_wr,
  input  wire logic [hfp_pkg::AW-1:0]    host_addr,
  input  wire logic [hfp_pkg::DW-1:0]    host_wdata,
  output logic      [hfp_pkg::DW-1:0]    host_rdata,
  output logic                           host_rvalid,
  output logic                           host_tx_full,
  input  wire logic                      rx_data_wr,
  input  wire logic [hfp_pkg::DW-1:0]    rx_data_in,
  output logic                           rx_data_full,
  input  wire logic                      rx_sts_wr,
  input  wire logic [hfp_pkg::DW-1:0]    rx_sts_in,
  output logic                           rx_sts_full,
  input  wire logic                      tx_sts_wr,
  input  wire logic [hfp_pkg::DW-1:0]    tx_sts_in,
  output logic                           tx_sts_full,
  input  wire logic                      tx_data_rd,
  output logic      [hfp_pkg::DW-1:0]    tx_data_out,
  output logic                           tx_data_valid,
  output logic                           tx_data_empty,
  input  wire logic                      ev_w1c_set,
  input  wire logic                      ev_rc_set,
  input  wire logic                      lh_in,
  input  wire logic                      ll_in
);
  hfp_pkg::hfp_state_t s_r;
  hfp_pkg::hfp_state_t s_nxt;

  logic [hfp_pkg::NF-1:0][hfp_pkg::FCW-1:0] lim;
  logic [hfp_pkg::NF-1:0]                   full;
  logic [hfp_pkg::NF-1:0]                   empty;
  logic [hfp_pkg::NF-1:0][hfp_pkg::DW-1:0]  head;
  logic [hfp_pkg::NF-1:0]                   push;
  logic [hfp_pkg::NF-1:0]                   pop;
  logic [hfp_pkg::NF-1:0][hfp_pkg::DW-1:0]  wval;
  logic                                     a_data;
  logic                                     rd_ev;

  assign a_data = (host_addr <= hfp_pkg::OFS_DATA_HI);
  assign rd_ev  = host_rd && (host_addr == hfp_pkg::OFS_EVENT);

  // depth limits: tx status has a fixed size, others follow cfg
  assign lim[hfp_pkg::F_RXD] = s_r.cfg[hfp_pkg::F_RXD*hfp_pkg::LANE_W +: hfp_pkg::FCW];
  assign lim[hfp_pkg::F_RXS] = s_r.cfg[hfp_pkg::F_RXS*hfp_pkg::LANE_W +: hfp_pkg::FCW];
  assign lim[hfp_pkg::F_TXS] = hfp_pkg::LIM_FIX;
  assign lim[hfp_pkg::F_TXD] = s_r.cfg[hfp_pkg::F_TXS*hfp_pkg::LANE_W +: hfp_pkg::FCW];

  genvar gi;
  generate
    for (gi = 0; gi < hfp_pkg::NF; gi++)
    begin : g_flag
      // limits above the array depth are clamped by the compare with LIM_FIX
      assign full[gi]  = (s_r.cnt[gi] >= lim[gi]) ||
                         (s_r.cnt[gi] == hfp_pkg::LIM_FIX);
      assign empty[gi] = (s_r.cnt[gi] == '0);
      assign head[gi]  = s_r.mem[gi][s_r.rptr[gi]];
    end
  endgenerate

  // host-side and device-side pops and pushes
  always_comb
  begin
    push = '0;
    pop  = '0;
    wval = '0;
    push[hfp_pkg::F_RXD] = rx_data_wr && !full[hfp_pkg::F_RXD];
    wval[hfp_pkg::F_RXD] = rx_data_in;
    push[hfp_pkg::F_RXS] = rx_sts_wr && !full[hfp_pkg::F_RXS];
    wval[hfp_pkg::F_RXS] = rx_sts_in;
    push[hfp_pkg::F_TXS] = tx_sts_wr && !full[hfp_pkg::F_TXS];
    wval[hfp_pkg::F_TXS] = tx_sts_in;
    // same alias range: reads hit rx data, writes hit tx data
    push[hfp_pkg::F_TXD] = host_wr && a_data && !full[hfp_pkg::F_TXD];
    wval[hfp_pkg::F_TXD] = host_wdata;
    pop[hfp_pkg::F_RXD]  = host_rd && a_data && !empty[hfp_pkg::F_RXD];
    pop[hfp_pkg::F_RXS]  = host_rd && (host_addr == hfp_pkg::OFS_RXS_POP) &&
                           !empty[hfp_pkg::F_RXS];
    pop[hfp_pkg::F_TXS]  = host_rd && (host_addr == hfp_pkg::OFS_TXS_POP) &&
                           !empty[hfp_pkg::F_TXS];
    pop[hfp_pkg::F_TXD]  = tx_data_rd && !empty[hfp_pkg::F_TXD];
  end

  always_comb
  begin
    s_nxt = s_r;
    for (int i = 0; i < hfp_pkg::NF; i++)
    begin
      if (push[i])
      begin
        s_nxt.mem[i][s_r.rptr[i] + s_r.cnt[i][hfp_pkg::FPW-1:0]] = wval[i];
      end
      if (pop[i])
      begin
        s_nxt.rptr[i] = s_r.rptr[i] + 4'h1;
      end
      s_nxt.cnt[i] = s_r.cnt[i] + {4'h0, push[i]} - {4'h0, pop[i]};
    end
    s_nxt.txd_valid = pop[hfp_pkg::F_TXD];
    if (pop[hfp_pkg::F_TXD])
    begin
      s_nxt.txd_out = head[hfp_pkg::F_TXD];
    end
    // read data; empty ports and write-only space read zero
    s_nxt.rvalid = host_rd;
    s_nxt.rdata  = hfp_pkg::ZERO_W;
    if (host_rd)
    begin
      if (a_data)
      begin
        s_nxt.rdata = empty[hfp_pkg::F_RXD] ? hfp_pkg::ZERO_W : head[hfp_pkg::F_RXD];
      end
      else
      begin
        case (host_addr)
          hfp_pkg::OFS_RXS_POP,
          hfp_pkg::OFS_RXS_PEEK: s_nxt.rdata = empty[hfp_pkg::F_RXS] ?
                                   hfp_pkg::ZERO_W : head[hfp_pkg::F_RXS];
          hfp_pkg::OFS_TXS_POP,
          hfp_pkg::OFS_TXS_PEEK: s_nxt.rdata = empty[hfp_pkg::F_TXS] ?
                                   hfp_pkg::ZERO_W : head[hfp_pkg::F_TXS];
          hfp_pkg::OFS_LEVEL:
          begin
            for (int i = 0; i < hfp_pkg::NF; i++)
            begin
              s_nxt.rdata[i*hfp_pkg::LANE_W +: hfp_pkg::FCW] = s_r.cnt[i];
            end
          end
          hfp_pkg::OFS_EVENT: s_nxt.rdata = {28'h0000000, s_r.ev};
          hfp_pkg::OFS_CFG:   s_nxt.rdata = s_r.cfg;
          hfp_pkg::OFS_CTRL:  s_nxt.rdata = hfp_pkg::ZERO_W;
          default:            s_nxt.rdata = hfp_pkg::ZERO_W;
        endcase
      end
    end
    // event bits: a set in the clearing cycle wins
    s_nxt.ev[hfp_pkg::EV_W1C] = ev_w1c_set || (s_r.ev[hfp_pkg::EV_W1C] &&
      !(host_wr && host_addr == hfp_pkg::OFS_EVENT &&
        host_wdata[hfp_pkg::EV_W1C]));
    s_nxt.ev[hfp_pkg::EV_RC] = ev_rc_set || (s_r.ev[hfp_pkg::EV_RC] && !rd_ev);
    s_nxt.ev[hfp_pkg::EV_LH] = lh_in || (s_r.ev[hfp_pkg::EV_LH] && !rd_ev);
    s_nxt.ev[hfp_pkg::EV_LL] = ll_in && (s_r.ev[hfp_pkg::EV_LL] || rd_ev);
    // level register, rx status ports and other offsets take no writes
    if (host_wr && host_addr == hfp_pkg::OFS_CFG)
    begin
      s_nxt.cfg = host_wdata;
    end
    s_nxt.srst_pend = host_wr && (host_addr == hfp_pkg::OFS_CTRL) &&
                      host_wdata[hfp_pkg::CTRL_SRST];
    // soft reset lands one cycle after the request and clears itself
    if (s_r.srst_pend)
    begin
      s_nxt.cnt       = '0;
      s_nxt.rptr      = '0;
      s_nxt.ev        = hfp_pkg::EV_RST;
      s_nxt.txd_valid = 1'b0;
      s_nxt.srst_pend = 1'b0;
      s_nxt.cfg       = hfp_pkg::CFG_RST;
      s_nxt.cfg[hfp_pkg::CFG_KEEP_LSB +: hfp_pkg::CFG_KEEP_W] =
        s_r.cfg[hfp_pkg::CFG_KEEP_LSB +: hfp_pkg::CFG_KEEP_W];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_r     <= '0;
      s_r.cfg <= hfp_pkg::CFG_RST;
      s_r.ev  <= hfp_pkg::EV_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign host_rdata    = s_r.rdata;
  assign host_rvalid   = s_r.rvalid;
  assign host_tx_full  = full[hfp_pkg::F_TXD];
  assign rx_data_full  = full[hfp_pkg::F_RXD];
  assign rx_sts_full   = full[hfp_pkg::F_RXS];
  assign tx_sts_full   = full[hfp_pkg::F_TXS];
  assign tx_data_out   = s_r.txd_out;
  assign tx_data_valid = s_r.txd_valid;
  assign tx_data_empty = empty[hfp_pkg::F_TXD];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence srst_req_s;
    host_wr && host_addr == hfp_pkg::OFS_CTRL && host_wdata[hfp_pkg::CTRL_SRST];
  endsequence
  sequence srst_done_s;
    s_r.srst_pend ##1 !s_r.srst_pend;
  endsequence

  ro_level_a: assert property (host_wr && host_addr == hfp_pkg::OFS_LEVEL &&
    !s_r.srst_pend |=> $stable(s_r.cfg)) else $error("level write changed cfg");
  wo_zero_a: assert property (host_rd && host_addr == hfp_pkg::OFS_CTRL |=>
    host_rvalid && host_rdata == hfp_pkg::ZERO_W) else $error("ctrl read not zero");
  w1c_clear_a: assert property (host_wr && host_addr == hfp_pkg::OFS_EVENT &&
    host_wdata[hfp_pkg::EV_W1C] && !ev_w1c_set |=> !s_r.ev[hfp_pkg::EV_W1C])
    else $error("w1c bit not cleared");
  w1c_keep_a: assert property (host_wr && host_addr == hfp_pkg::OFS_EVENT &&
    !host_wdata[hfp_pkg::EV_W1C] && s_r.ev[hfp_pkg::EV_W1C] && !s_r.srst_pend |=>
    s_r.ev[hfp_pkg::EV_W1C]) else $error("w1c bit lost on zero write");
  rc_clear_a: assert property (rd_ev && !ev_rc_set && !s_r.srst_pend |=>
    !s_r.ev[hfp_pkg::EV_RC]) else $error("rc bit not cleared");
  lh_hold_a: assert property (s_r.ev[hfp_pkg::EV_LH] && !rd_ev && !s_r.srst_pend |=>
    s_r.ev[hfp_pkg::EV_LH]) else $error("latched bit dropped early");
  srst_keep_a: assert property (s_r.srst_pend |=> s_r.cnt == '0 &&
    s_r.cfg[hfp_pkg::CFG_KEEP_LSB +: hfp_pkg::CFG_KEEP_W] ==
    $past(s_r.cfg[hfp_pkg::CFG_KEEP_LSB +: hfp_pkg::CFG_KEEP_W]))
    else $error("soft reset lost retained field");
  sc_clear_a: assert property (srst_req_s |=> srst_done_s)
    else $error("soft reset bit not self-cleared");
  rxs_pop_a: assert property (host_rd && host_addr == hfp_pkg::OFS_RXS_POP &&
    !empty[hfp_pkg::F_RXS] && !rx_sts_wr && !s_r.srst_pend |=>
    s_r.cnt[hfp_pkg::F_RXS] == $past(s_r.cnt[hfp_pkg::F_RXS]) - 5'h01 &&
    host_rdata == $past(head[hfp_pkg::F_RXS])) else $error("rx status pop wrong");
  rxs_peek_a: assert property (host_rd && host_addr == hfp_pkg::OFS_RXS_PEEK &&
    !rx_sts_wr && !s_r.srst_pend |=> $stable(s_r.cnt[hfp_pkg::F_RXS]))
    else $error("rx status peek popped");
  txs_peek_a: assert property (host_rd && host_addr == hfp_pkg::OFS_TXS_PEEK &&
    !tx_sts_wr && !s_r.srst_pend |=> $stable(s_r.cnt[hfp_pkg::F_TXS]))
    else $error("tx status peek popped");
  rxd_alias_a: assert property (host_rd && a_data && !empty[hfp_pkg::F_RXD] &&
    !rx_data_wr && !s_r.srst_pend |=>
    s_r.cnt[hfp_pkg::F_RXD] == $past(s_r.cnt[hfp_pkg::F_RXD]) - 5'h01)
    else $error("rx data alias did not pop");
  rxs_nowr_a: assert property (host_wr && host_addr == hfp_pkg::OFS_RXS_POP &&
    !rx_sts_wr && !s_r.srst_pend |=> $stable(s_r.cnt[hfp_pkg::F_RXS]))
    else $error("rx status port took a write");
  // fifo bookkeeping; the host never reads and writes in one cycle
  txs_pop_a: assert property (host_rd && host_addr == hfp_pkg::OFS_TXS_POP &&
    !empty[hfp_pkg::F_TXS] && !tx_sts_wr && !s_r.srst_pend |=>
    s_r.cnt[hfp_pkg::F_TXS] == $past(s_r.cnt[hfp_pkg::F_TXS]) - 5'h01 &&
    host_rdata == $past(head[hfp_pkg::F_TXS])) else $error("tx status pop wrong");
  rxs_peek_data_a: assert property (host_rd &&
    host_addr == hfp_pkg::OFS_RXS_PEEK && !empty[hfp_pkg::F_RXS] |=>
    host_rdata == $past(head[hfp_pkg::F_RXS])) else $error("rx status peek data wrong");
  rxd_empty_a: assert property (host_rd && a_data && empty[hfp_pkg::F_RXD] |=>
    host_rdata == hfp_pkg::ZERO_W) else $error("empty rx data read not zero");
  rxd_nowr_a: assert property (host_wr && a_data && !host_rd && !rx_data_wr &&
    !s_r.srst_pend |=> $stable(s_r.cnt[hfp_pkg::F_RXD])) else $error("rx data took a write");
  txd_push_a: assert property (host_wr && a_data && !full[hfp_pkg::F_TXD] &&
    !tx_data_rd && !s_r.srst_pend |=>
    s_r.cnt[hfp_pkg::F_TXD] == $past(s_r.cnt[hfp_pkg::F_TXD]) + 5'h01)
    else $error("tx data write not pushed");
  txd_out_a: assert property (tx_data_rd && !empty[hfp_pkg::F_TXD] &&
    !s_r.srst_pend |=> tx_data_valid && tx_data_out == $past(head[hfp_pkg::F_TXD]))
    else $error("tx data pop wrong");
  rxs_push_a: assert property (rx_sts_wr && !full[hfp_pkg::F_RXS] && !host_rd &&
    !s_r.srst_pend |=>
    s_r.cnt[hfp_pkg::F_RXS] == $past(s_r.cnt[hfp_pkg::F_RXS]) + 5'h01)
    else $error("rx status push lost");
  rxs_full_a: assert property (rx_sts_wr && full[hfp_pkg::F_RXS] && !host_rd &&
    !s_r.srst_pend |=> $stable(s_r.cnt[hfp_pkg::F_RXS])) else $error("full rx status grew");
  // the fixed-size tx status fifo can never hold more than its depth
  txs_depth_a: assert property (s_r.cnt[hfp_pkg::F_TXS] <= hfp_pkg::LIM_FIX)
    else $error("tx status fifo overfilled");
  ev_ro_a: assert property (host_wr && host_addr == hfp_pkg::OFS_EVENT &&
    !host_rd && !lh_in && !s_r.srst_pend |=>
    s_r.ev[hfp_pkg::EV_LH] == $past(s_r.ev[hfp_pkg::EV_LH]))
    else $error("write reached latched bit");
  w1c_set_a: assert property (ev_w1c_set && !s_r.srst_pend |=>
    s_r.ev[hfp_pkg::EV_W1C]) else $error("w1c set lost to clear");
  rc_set_a: assert property (ev_rc_set && !s_r.srst_pend |=>
    s_r.ev[hfp_pkg::EV_RC]) else $error("rc set lost to read");
  ll_hold_a: assert property (!s_r.ev[hfp_pkg::EV_LL] && !rd_ev &&
    !s_r.srst_pend |=> !s_r.ev[hfp_pkg::EV_LL]) else $error("latch-low bit recovered early");
  srst_dflt_a: assert property (s_r.srst_pend |=> s_r.ev == hfp_pkg::EV_RST &&
    !tx_data_valid) else $error("soft reset left events set");
  // checked through reset itself, so the default disable is overridden
  rst_dflt_a: assert property (disable iff (1'b0) rst |=>
    s_r.cfg == hfp_pkg::CFG_RST && s_r.ev == hfp_pkg::EV_RST && s_r.cnt == '0)
    else $error("hardware reset defaults wrong");
endmodule // hfp_top

// *** tb/hfp_host.sv ***
`timescale 1ns/10ps
module hfp_host (
  input  wire logic                   clk_sys,
  input  wire logic [hfp_pkg::DW-1:0] host_rdata,
  input  wire logic                   host_rvalid,
  output logic                        host_rd,
  output logic                        host_wr,
  output logic      [hfp_pkg::AW-1:0] host_addr,
  output logic      [hfp_pkg::DW-1:0] host_wdata
);
  initial
  begin
    host_rd    = 1'b0;
    host_wr    = 1'b0;
    host_addr  = 8'h00;
    host_wdata = 32'h0000_0000;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    // nothing above the control word is ever written
    if (a > hfp_pkg::OFS_CTRL) return;
    @(posedge clk_sys);
    host_wr    <= 1'b1;
    host_addr  <= a;
    host_wdata <= (a == hfp_pkg::OFS_CFG) ? (d & 32'hFF1F_1F1F) : d;
    @(posedge clk_sys);
    host_wr    <= 1'b0;
    // stale data must not look held
    host_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    host_rd   <= 1'b1;
    host_addr <= a;
    @(posedge clk_sys);
    host_rd <= 1'b0;
    #1;
    // missing answer poisons the value
    d = host_rvalid ? host_rdata : 32'hXXXX_XXXX;
  endtask
endmodule // hfp_host

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  localparam logic [31:0] M = 32'hFFFF_FFFF;
  logic        clk_sys   = 1'b0;
  logic        rst       = 1'b1;
  // strobes: rxd, rxs, txs push, w1c, rc, lh, ll low, tx pop
  logic [7:0]  st        = 8'h00;
  logic [31:0] pd        = 32'h0000_0000;
  logic [31:0] seed      = 32'h0000_002B;
  logic [31:0] d;
  logic [7:0]  a;
  logic [31:0] q[$];
  int          err_count = 0;
  int          n_checks  = 0;
  logic host_rd, host_wr, host_rvalid, host_tx_full, rx_data_full, rx_sts_full;
  logic tx_sts_full, tx_data_valid, tx_data_empty;
  logic [7:0]  host_addr;
  logic [31:0] host_wdata, host_rdata, tx_data_out;
  always #5 clk_sys = ~clk_sys;
  hfp_top u_dut (
    .clk_sys, .rst, .host_rd, .host_wr, .host_addr, .host_wdata, .host_rdata,
    .host_rvalid, .host_tx_full, .rx_data_wr(st[0]), .rx_data_in(pd), .rx_data_full,
    .rx_sts_wr(st[1]), .rx_sts_in(pd), .rx_sts_full, .tx_sts_wr(st[2]), .tx_sts_in(pd),
    .tx_sts_full, .tx_data_rd(st[7]), .tx_data_out, .tx_data_valid, .tx_data_empty,
    .ev_w1c_set(st[3]), .ev_rc_set(st[4]), .lh_in(st[5]), .ll_in(~st[6])
  );
  hfp_host u_host (
    .clk_sys, .host_rdata, .host_rvalid, .host_rd, .host_wr, .host_addr, .host_wdata
  );
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp, input logic [31:0] m);
    u_host.rd(ad, d);
    chk(d & m, exp);
  endtask
  task automatic pulse(input int i, input logic [31:0] v);
    @(posedge clk_sys);
    st[i] <= 1'b1;
    pd    <= v;
    @(posedge clk_sys);
    st[i] <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_count++;
    finish_test();
  end
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rchk(hfp_pkg::OFS_EVENT, 32'h0000_0008, 32'h0000_000F);
    rchk(hfp_pkg::OFS_CFG, hfp_pkg::CFG_RST, M);
    u_host.wr(hfp_pkg::OFS_LEVEL, xs());
    rchk(hfp_pkg::OFS_LEVEL, 32'h0000_0000, M);
    rchk(hfp_pkg::OFS_CTRL, 32'h0000_0000, M);
    for (int i = 0; i < 16; i++)
    begin
      q.push_back(xs());
      pulse(0, q[i]);
    end
    u_host.wr(hfp_pkg::OFS_RXS_POP, xs());
    #1;
    chk({31'h0, rx_data_full}, 32'h1);
    rchk(hfp_pkg::OFS_LEVEL, 32'h0000_0010, M);
    for (int i = 0; i < 16; i++)
      rchk(8'(4 * i), q.pop_front(), M);
    rchk(8'h00, 32'h0000_0000, M);
    for (int f = 1; f < 3; f++)
    begin
      a = (f == 1) ? hfp_pkg::OFS_RXS_POP : hfp_pkg::OFS_TXS_POP;
      q = {xs(), xs()};
      pulse(f, q[0]);
      pulse(f, q[1]);
      rchk(a + 8'h04, q[0], M);
      rchk(a + 8'h04, q[0], M);
      rchk(a, q[0], M);
      rchk(a, q[1], M);
    end
    q = {};
    for (int i = 0; i < 16; i++)
    begin
      q.push_back(xs());
      u_host.wr(8'(4 * (15 - i)), q[i]);
    end
    #1;
    chk({31'h0, host_tx_full}, 32'h1);
    chk({31'h0, tx_data_empty}, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      pulse(7, pd);
      #1;
      chk(tx_data_valid ? tx_data_out : 32'hXXXX_XXXX, q[i]);
    end
    chk({31'h0, tx_data_empty}, 32'h1);
    pulse(3, pd);
    u_host.wr(hfp_pkg::OFS_EVENT, 32'h0000_0000);
    rchk(hfp_pkg::OFS_EVENT, 32'h0000_0001, 32'h0000_0001);
    u_host.wr(hfp_pkg::OFS_EVENT, 32'h0000_0001);
    rchk(hfp_pkg::OFS_EVENT, 32'h0000_0000, 32'h0000_0001);
    pulse(4, pd);
    rchk(hfp_pkg::OFS_EVENT, 32'h0000_0002, 32'h0000_0002);
    rchk(hfp_pkg::OFS_EVENT, 32'h0000_0000, 32'h0000_0002);
    pulse(5, pd);
    pulse(6, pd);
    rchk(hfp_pkg::OFS_EVENT, 32'h0000_0004, 32'h0000_000C);
    rchk(hfp_pkg::OFS_EVENT, 32'h0000_0008, 32'h0000_000C);
    u_host.wr(hfp_pkg::OFS_CFG, 32'hAB0F_0F02);
    rchk(hfp_pkg::OFS_CFG, 32'hAB0F_0F02, M);
    for (int i = 0; i < 3; i++)
      pulse(0, xs());
    #1;
    chk({31'h0, rx_data_full}, 32'h1);
    rchk(hfp_pkg::OFS_LEVEL, 32'h0000_0002, 32'h0000_001F);
    u_host.wr(hfp_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk_sys);
    rchk(hfp_pkg::OFS_CFG, 32'hAB10_1010, M);
    rchk(hfp_pkg::OFS_LEVEL, 32'h0000_0000, M);
    rchk(hfp_pkg::OFS_CTRL, 32'h0000_0000, M);
    u_host.wr(hfp_pkg::OFS_CFG, 32'h0010_0010);
    rchk(hfp_pkg::OFS_CFG, 32'h0010_0010, M);
    chk({31'h0, rx_sts_full}, 32'h1);
    chk({31'h0, tx_sts_full}, 32'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rchk(hfp_pkg::OFS_CFG, hfp_pkg::CFG_RST, M);
    finish_test();
  end
endmodule // testbench
